// file: sim/pulse_disp_model.sv
// Purpose: count pulse source and scanned display capture
// Assumes: pulses paced by core_clk, each pin level held two cycles
// Notes: keeps the last segment pattern seen for each digit
`timescale 1ns/1ps
module pulse_disp_model
	import counter_disp_pkg::*;
(
	// clock and arming
	input wire logic core_clk,
	input wire logic armed,
	// count pin
	output logic count_clk,
	// display
	input wire disp_t disp,
	output logic [DIGITS-1:0][6:0] shown,
	output logic bad_sel
);
	initial
	begin
		count_clk = 1'b1;
		shown = '0;
		bad_sel = 1'b0;
	end

	// two cycles per level, the shortest the pin filter accepts
	task automatic pulse(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			count_clk <= 1'b0;
			repeat (2) @(posedge core_clk);
			count_clk <= 1'b1;
			@(posedge core_clk);
		end
	endtask

	always @(posedge core_clk)
	begin
		if (armed && !$onehot(disp.digit_sel))
			bad_sel <= 1'b1;
		for (int i = 0; i < DIGITS; i++)
			if (disp.digit_sel[i])
				shown[i] <= disp.seg;
	end
endmodule

// file: sim/tb.sv
// Purpose: self-checking bench for the counter with scanned display
// Assumes: four cycles per scan step from reset, five once the bench rewrites the divider; time, half and base variants share pins and bus
// Notes: registers reached over APB; count pin driven by the partner model, view and hold pins by the bench
`timescale 1ns/1ps
module tb
	import counter_disp_pkg::*;
;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clear_in = 1'b0;
	logic view_r = 1'b1;
	logic pass_r = 1'b1;
	logic armed = 1'b0;
	logic cnt;
	pins_t pins;
	logic carry_out;
	disp_t disp;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [DIGITS-1:0][6:0] shown;
	logic bad_sel;
	logic [31:0] q;
	logic e;
	// index 0 time, 1 half, 2 base
	logic [2:0][31:0] prdata_v;
	logic [2:0][31:0] qv;
	logic [2:0] carry_v;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	localparam logic [6:0] SEG_TAB [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
		7'h07, 7'h7F, 7'h6F};

	assign pins = '{view_sel: view_r, latch_pass: pass_r, count_clk: cnt};
	always #12.5 core_clk = ~core_clk;

	counter_disp #(.VARIANT(VAR_CASCADE), .SCAN_STEP_CYC(4)) uut (.core_clk(core_clk),
		.sys_rst(sys_rst), .pins_in(pins), .clear_in(clear_in), .carry_out(carry_out),
		.disp_out(disp), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	counter_disp #(.VARIANT(VAR_TIME), .SCAN_STEP_CYC(4)) uut_time (.core_clk(core_clk),
		.sys_rst(sys_rst), .pins_in(pins), .clear_in(clear_in), .carry_out(carry_v[0]),
		.disp_out(), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata_v[0]), .pready(), .pslverr());
	counter_disp #(.VARIANT(VAR_HALF), .SCAN_STEP_CYC(4)) uut_half (.core_clk(core_clk),
		.sys_rst(sys_rst), .pins_in(pins), .clear_in(clear_in), .carry_out(carry_v[1]),
		.disp_out(), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata_v[1]), .pready(), .pslverr());
	counter_disp #(.VARIANT(VAR_BASE), .SCAN_STEP_CYC(4)) uut_base (.core_clk(core_clk),
		.sys_rst(sys_rst), .pins_in(pins), .clear_in(clear_in), .carry_out(carry_v[2]),
		.disp_out(), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata_v[2]), .pready(), .pslverr());
	pulse_disp_model far (.core_clk(core_clk), .armed(armed), .count_clk(cnt),
		.disp(disp), .shown(shown), .bad_sel(bad_sel));

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic print_verdict;
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge core_clk);
		end
		if (n == 50)
			num_errors++;
		q = prdata;
		qv = prdata_v;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, exp, q);
	endtask

	// scan must rotate a few times after a pin change
	task automatic chk_disp(input logic [15:0] v);
		repeat (80) @(posedge core_clk);
		for (int i = 0; i < DIGITS; i++)
			chk("segments", {25'h0, SEG_TAB[v[i*4+:4]]}, {25'h0, shown[i]});
	endtask

	task automatic pulses(input int n);
		far.pulse(n);
		repeat (8) @(posedge core_clk);
	endtask

	// ************************************************************
	// sequence
	// ************************************************************
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			num_errors++;
			print_verdict;
		end
	end

	initial
	begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		armed <= 1'b1;
		rd(REG_LIVE, 32'h0, "live count");
		rd(REG_STATUS, 32'h1E, "status");
		chk("time status", 32'h2E, qv[0]);
		chk("half status", 32'h3E, qv[1]);
		chk("base status", 32'h0C, qv[2]);
		rd(REG_SCAN_DIV, 32'h4, "scan divider");
		apb(1'b1, REG_SCAN_DIV, 32'h5);
		rd(REG_SCAN_DIV, 32'h5, "scan divider");
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		apb(1'b1, REG_LIVE, 32'h1234);
		rd(REG_LIVE, 32'h0, "read-only live");
		pulses(5);
		rd(REG_LIVE, 32'h5, "live count");
		pass_r <= 1'b0;
		repeat (8) @(posedge core_clk);
		pulses(3);
		rd(REG_LIVE, 32'h8, "live count");
		rd(REG_HELD, 32'h5, "held count");
		chk_disp(16'h0008);
		view_r <= 1'b0;
		chk_disp(16'h0005);
		pass_r <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd(REG_HELD, 32'h8, "held count");
		pulses(5991);
		rd(REG_LIVE, 32'h5999, "live count");
		chk("time count", 32'h9599, qv[0]);
		chk("half count", 32'h1999, qv[1]);
		chk("base count", 32'h5999, qv[2]);
		chk("carry", 32'h0, {31'h0, carry_out});
		chk("time carry", 32'h1, {31'h0, carry_v[0]});
		chk("half carry", 32'h1, {31'h0, carry_v[1]});
		chk("base carry", 32'h0, {31'h0, carry_v[2]});
		pulses(1);
		chk("carry", 32'h1, {31'h0, carry_out});
		chk("time carry", 32'h0, {31'h0, carry_v[0]});
		chk("half carry", 32'h1, {31'h0, carry_v[1]});
		@(posedge core_clk);
		clear_in <= 1'b1;
		#1;
		chk("carry", 32'h0, {31'h0, carry_out});
		chk("half carry", 32'h0, {31'h0, carry_v[1]});
		rd(REG_LIVE, 32'h0, "cleared count");
		@(posedge core_clk);
		clear_in <= 1'b0;
		pulses(6000);
		chk("carry", 32'h1, {31'h0, carry_out});
		chk("time carry", 32'h0, {31'h0, carry_v[0]});
		chk("half carry", 32'h1, {31'h0, carry_v[1]});
		pulses(4000);
		chk("carry", 32'h0, {31'h0, carry_out});
		chk("time carry", 32'h1, {31'h0, carry_v[0]});
		chk("half carry", 32'h1, {31'h0, carry_v[1]});
		chk("base carry", 32'h0, {31'h0, carry_v[2]});
		rd(REG_LIVE, 32'h0, "wrapped count");
		chk("time count", 32'h6400, qv[0]);
		chk("half count", 32'h0, qv[1]);
		chk("base count", 32'h0, qv[2]);
		chk("digit select", 32'h0, {31'h0, bad_sel});
		print_verdict;
	end
endmodule

// file: src/counter_disp.sv
// Purpose: four digit event counter, hold latch and multiplexed seven segment scanner
// Assumes: pins are asynchronous to core_clk; clear_in is an asynchronous clear
// Notes: status and scan rate visible over APB; one wait state on every access
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module counter_disp
	import counter_disp_pkg::*;
#(
	parameter logic [1:0] VARIANT = VAR_CASCADE,
	parameter int SCAN_STEP_CYC = SCAN_STEP_CYC_DEF
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// counter pins
	input wire pins_t pins_in,
	input wire logic clear_in,
	output logic carry_out,
	// display
	output disp_t disp_out,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ************************************************************
	// pin synchronisers and filter
	// ************************************************************
	pins_t pin_s1_r;
	pins_t pin_s2_r;
	pins_t pin_s3_r;
	pins_t pin_f_r;
	logic clk_prev_r;
	logic cnt_fall;

	// a level is accepted only once two late stages agree
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			pin_f_r <= '0;
		end
		else
		begin
			pin_s1_r <= pins_in;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			for (int i = 0; i < $bits(pins_t); i++)
			begin
				if (pin_s2_r[i] == pin_s3_r[i])
					pin_f_r[i] <= pin_s3_r[i];
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			clk_prev_r <= 1'b0;
		else
			clk_prev_r <= pin_f_r.count_clk;
	end

	// falling edge only; rising edges are ignored
	assign cnt_fall = clk_prev_r & ~pin_f_r.count_clk;

	// ************************************************************
	// counter and carry
	// ************************************************************
	count_t count_r;
	count_t count_nxt;
	logic carry_r;
	logic carry_nxt;

	assign count_nxt = count_inc(count_r, VARIANT);

	always_comb
	begin
		carry_nxt = carry_r;
		case (VARIANT)
			VAR_CASCADE, VAR_TIME:
			begin
				if (count_nxt == CARRY_SET_VAL)
					carry_nxt = 1'b1;
				else if (count_nxt == COUNT_ZERO)
					carry_nxt = 1'b0;
			end
			VAR_HALF:
			begin
				// wrap out of the top count is the overflow
				if (count_nxt == COUNT_ZERO)
					carry_nxt = 1'b1;
			end
			default:
				carry_nxt = 1'b0;
		endcase
	end

	// clear is a raw pin used as an async clear; release may land mid cycle,
	// costing at most one count edge that arrives right at release
	always_ff @(posedge core_clk or posedge clear_in)
	begin
		if (clear_in)
			count_r <= '0;
		else if (sys_rst)
			count_r <= '0;
		else if (cnt_fall)
			count_r <= count_nxt;
	end

	always_ff @(posedge core_clk or posedge clear_in)
	begin
		if (clear_in)
			carry_r <= 1'b0;
		else if (sys_rst)
			carry_r <= 1'b0;
		else if (cnt_fall)
			carry_r <= carry_nxt;
	end

	assign carry_out = carry_r;

	// ************************************************************
	// hold latch and view select
	// ************************************************************
	count_t held_r;
	count_t disp_val;
	logic view_live;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			held_r <= '0;
		else if (pin_f_r.latch_pass)
			held_r <= count_r;
	end

	// base variant has no view pin: it always shows the latch
	assign view_live = (VARIANT != VAR_BASE) && pin_f_r.view_sel;
	assign disp_val = view_live ? count_r : held_r;

	// ************************************************************
	// scan oscillator and digit drive
	// ************************************************************
	logic [SCAN_W-1:0] scan_div_r;
	logic [SCAN_W-1:0] scan_cnt_r;
	logic [1:0] digit_idx_r;
	logic scan_tick;
	logic [3:0] cur_digit;
	disp_t disp_r;

	// a divider of zero behaves as one so the scan never freezes
	assign scan_tick = (scan_cnt_r + SCAN_W'(1)) >= scan_div_r;
	assign cur_digit = disp_val[digit_idx_r];

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			scan_cnt_r <= '0;
		else if (scan_tick)
			scan_cnt_r <= '0;
		else
			scan_cnt_r <= scan_cnt_r + SCAN_W'(1);
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			digit_idx_r <= 2'h0;
		else if (scan_tick)
			digit_idx_r <= digit_idx_r + 2'h1;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			disp_r <= '0;
		else
		begin
			disp_r.digit_sel <= 4'h1 << digit_idx_r;
			disp_r.seg <= seg_of(cur_digit);
		end
	end

	assign disp_out = disp_r;

	// ************************************************************
	// apb slave
	// ************************************************************
	logic ready_r;
	logic [31:0] rdata_r;
	logic err_r;
	logic access;
	logic mapped;
	logic [31:0] rd_mux;

	assign access = psel & penable;
	assign mapped = (paddr == REG_LIVE) || (paddr == REG_HELD) ||
		(paddr == REG_STATUS) || (paddr == REG_SCAN_DIV);

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			REG_LIVE: rd_mux[15:0] = count_r;
			REG_HELD: rd_mux[15:0] = held_r;
			REG_STATUS:
			begin
				rd_mux[ST_CARRY] = carry_r;
				rd_mux[ST_VIEW] = view_live;
				rd_mux[ST_PASS] = pin_f_r.latch_pass;
				rd_mux[ST_CLK] = pin_f_r.count_clk;
				rd_mux[ST_VAR_LO +: 2] = VARIANT;
			end
			REG_SCAN_DIV: rd_mux[SCAN_W-1:0] = scan_div_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait state keeps read data registered
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ready_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end
		else
		begin
			ready_r <= access & ~ready_r;
			if (access && !ready_r)
			begin
				rdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
				err_r <= ~mapped;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			scan_div_r <= SCAN_W'(SCAN_STEP_CYC);
		else if (access && ready_r && pwrite && paddr == REG_SCAN_DIV)
			scan_div_r <= pwdata[SCAN_W-1:0];
	end

	assign pready = ready_r;
	assign prdata = rdata_r;
	assign pslverr = ready_r & err_r;

	// ************************************************************
	// checks
	// ************************************************************
	property p_count_stable;
		@(posedge core_clk) disable iff (sys_rst || clear_in)
		!cnt_fall |=> $stable(count_r);
	endproperty
	a_count_stable: assert property (p_count_stable)
		else $error("count moved without a falling count edge");

	property p_count_step;
		@(posedge core_clk) disable iff (sys_rst || clear_in)
		cnt_fall |=> count_r == $past(count_nxt);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("count did not step on falling edge");

	property p_clear;
		@(posedge core_clk) disable iff (sys_rst)
		clear_in |-> (count_r == COUNT_ZERO) && !carry_out;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not zero count and carry");

	property p_hold;
		@(posedge core_clk) disable iff (sys_rst)
		!pin_f_r.latch_pass ##1 !pin_f_r.latch_pass |-> $stable(held_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("held value changed while holding");

	property p_pass;
		@(posedge core_clk) disable iff (sys_rst)
		pin_f_r.latch_pass |=> held_r == $past(count_r);
	endproperty
	a_pass: assert property (p_pass)
		else $error("latch not transparent");

	property p_seg;
		@(posedge core_clk) disable iff (sys_rst)
		view_live ##1 1'b1 |-> disp_out.seg == seg_of($past(count_r[digit_idx_r]));
	endproperty
	a_seg: assert property (p_seg)
		else $error("live view shows wrong segments");

	property p_onehot;
		@(posedge core_clk) disable iff (sys_rst)
		$past(!sys_rst) |-> $onehot(disp_out.digit_sel);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("digit select not one hot");

	property p_scan_step;
		@(posedge core_clk) disable iff (sys_rst)
		scan_tick |=> digit_idx_r == 2'($past(digit_idx_r) + 2'h1);
	endproperty
	a_scan_step: assert property (p_scan_step)
		else $error("scan did not advance");

	property p_carry_set;
		@(posedge core_clk) disable iff (sys_rst || clear_in)
		(VARIANT == VAR_CASCADE || VARIANT == VAR_TIME) && cnt_fall &&
			count_nxt == CARRY_SET_VAL |=> carry_out;
	endproperty
	a_carry_set: assert property (p_carry_set)
		else $error("carry did not rise at 6000");

	property p_carry_wrap;
		@(posedge core_clk) disable iff (sys_rst || clear_in)
		VARIANT != VAR_HALF && cnt_fall && count_nxt == COUNT_ZERO |=> !carry_out;
	endproperty
	a_carry_wrap: assert property (p_carry_wrap)
		else $error("carry did not fall on wrap");

	property p_sticky;
		@(posedge core_clk) disable iff (sys_rst || clear_in)
		VARIANT == VAR_HALF && carry_out |=> carry_out;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("overflow flag dropped without clear");

	property p_digit_range;
		@(posedge core_clk) disable iff (sys_rst)
		(count_r[TIME_DIGIT] <= digit_max(VARIANT, TIME_DIGIT)) &&
			(count_r[HALF_DIGIT] <= digit_max(VARIANT, HALF_DIGIT));
	endproperty
	a_digit_range: assert property (p_digit_range)
		else $error("digit beyond its modulus");

	property p_base_carry;
		@(posedge core_clk) disable iff (sys_rst)
		VARIANT == VAR_BASE |-> !carry_out && !view_live;
	endproperty
	a_base_carry: assert property (p_base_carry)
		else $error("base variant drives carry or live view");

	property p_apb_ready;
		@(posedge core_clk) disable iff (sys_rst)
		access && !pready |=> pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready)
		else $error("apb access not answered in one wait state");

endmodule

// file: src/counter_disp_pkg.sv
// Purpose: constants, types and helpers for the four digit counter with scanned display
// Assumes: 40 MHz core clock, BCD digits, common cathode segment order {g,f,e,d,c,b,a}
// Notes: digits are BCD, digit 0 least significant
// Function
// - count once per falling count clock edge
// - clear high zeroes digits and carry asynchronously
// - hold low keeps count, high passes through
// - view high shows live, low shows held
// - own oscillator paces scan, four digit selects
// - base variant: four decades, no view, no carry
// - extended variants add view select and carry
// - cascade carry rises at 6000, falls 0000
// - time variant: digit 2 counts modulo six
// - half variant: top digit counts modulo two
// - half variant carry sticky overflow until clear
package counter_disp_pkg;

	// ************************************************************
	// variants and digits
	// ************************************************************
	localparam logic [1:0] VAR_BASE = 2'h0;
	localparam logic [1:0] VAR_CASCADE = 2'h1;
	localparam logic [1:0] VAR_TIME = 2'h2;
	localparam logic [1:0] VAR_HALF = 2'h3;
	localparam int DIGITS = 4;
	localparam int TIME_DIGIT = 2;
	localparam int HALF_DIGIT = 3;
	localparam logic [3:0] DIG_MAX_DEC = 4'h9;
	localparam logic [3:0] DIG_MAX_SIX = 4'h5;
	localparam logic [3:0] DIG_MAX_TWO = 4'h1;
	localparam logic [15:0] CARRY_SET_VAL = 16'h6000;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;

	// ************************************************************
	// scan timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCAN_STEP_NS = 1000000;
	localparam int SCAN_STEP_CYC_DEF = (SCAN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCAN_W = 24;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int APB_AW = 8;
	localparam logic [7:0] REG_LIVE = 8'h00;
	localparam logic [7:0] REG_HELD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_SCAN_DIV = 8'h0C;
	localparam int ST_CARRY = 0;
	localparam int ST_VIEW = 1;
	localparam int ST_PASS = 2;
	localparam int ST_CLK = 3;
	localparam int ST_VAR_LO = 4;

	// ************************************************************
	// types
	// ************************************************************
	typedef logic [DIGITS-1:0][3:0] count_t;
	typedef struct packed {
		logic view_sel;
		logic latch_pass;
		logic count_clk;
	} pins_t;
	typedef struct packed {
		logic [DIGITS-1:0] digit_sel;
		logic [6:0] seg;
	} disp_t;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [3:0] digit_max(input logic [1:0] v, input int i);
		if (v == VAR_TIME && i == TIME_DIGIT)
			return DIG_MAX_SIX;
		if (v == VAR_HALF && i == HALF_DIGIT)
			return DIG_MAX_TWO;
		return DIG_MAX_DEC;
	endfunction

	function automatic count_t count_inc(input count_t c, input logic [1:0] v);
		count_t r;
		logic cy;
		r = c;
		cy = 1'b1;
		for (int i = 0; i < DIGITS; i++)
		begin
			if (cy)
			begin
				if (c[i] >= digit_max(v, i))
					r[i] = 4'h0;
				else
				begin
					r[i] = c[i] + 4'h1;
					cy = 1'b0;
				end
			end
		end
		return r;
	endfunction

	function automatic logic [6:0] seg_of(input logic [3:0] d);
		case (d)
			4'h0: return 7'h3F;
			4'h1: return 7'h06;
			4'h2: return 7'h5B;
			4'h3: return 7'h4F;
			4'h4: return 7'h66;
			4'h5: return 7'h6D;
			4'h6: return 7'h7D;
			4'h7: return 7'h07;
			4'h8: return 7'h7F;
			4'h9: return 7'h6F;
			default: return 7'h00;
		endcase
	endfunction

endpackage
